// File: hw/anpr_pkg.sv
// Package of the auto-negotiation page register bank
package anpr_pkg;

	// Avalon byte address width and word index width
	localparam int ADR_W = 6;
	localparam int IDX_W = 4;
	localparam int WRD_LSB = 2;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_ADV  = 4'h4;
	localparam logic [IDX_W-1:0] IDX_LPA  = 4'h5;
	localparam logic [IDX_W-1:0] IDX_EXP  = 4'h6;
	localparam logic [IDX_W-1:0] IDX_NPTX = 4'h7;
	localparam logic [IDX_W-1:0] IDX_LPNP = 4'h8;

	// Shared field positions of ability and page words
	localparam int B_NP    = 15;
	localparam int B_ACK   = 14;
	localparam int B_RF    = 13;
	localparam int B_MP    = 13;
	localparam int B_ACK2  = 12;
	localparam int B_TOG   = 11;
	localparam int B_T4    = 9;
	localparam int B_100FD = 8;
	localparam int B_100   = 7;
	localparam int B_10FD  = 6;

	// Expansion register field positions
	localparam int B_PDF   = 4;
	localparam int B_LPNPA = 3;
	localparam int B_NPA   = 2;
	localparam int B_PRX   = 1;
	localparam int B_LPAN  = 0;

	// Reset values, writable-bit masks and partner load masks
	localparam logic [15:0] ADV_RST  = 16'h0021;
	localparam logic [15:0] ADV_WMSK = 16'hA5FF;
	localparam logic [15:0] LPA_RST  = 16'h0001;
	localparam logic [15:0] LPA_MSK  = 16'hEFFF;
	localparam logic [15:0] NP_RST   = 16'h2001;
	localparam logic [15:0] NP_WMSK  = 16'hB7FF;
	localparam logic [15:0] LPNP_MSK = 16'hF000;
	localparam logic [15:0] ZERO16   = 16'h0000;

	// Avalon-MM request carried as one bundle
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADR_W-1:0]  address;
		logic [3:0]        byteenable;
		logic [31:0]       writedata;
	} anpr_avs_req_t;

	// Whole state of the register bank
	typedef struct packed {
		logic        wreq;
		logic [31:0] rdata;
		logic [15:0] adv;
		logic [15:0] lpa;
		logic [15:0] np;
		logic [15:0] lpnp;
		logic        pdf;
		logic        prx;
		logic        lpan;
	} anpr_state_t;

endpackage

// File: hw/anpr_regs.sv
// Auto-negotiation ability and page register bank with Avalon-MM slave
// Operation
// (RL1) Advertise next page: RW, reset 0
// (RL2) Advertise remote fault: RW, reset 0
// (RL3) Advertise pause: RW, reset 0
// (RL4) T4 and reserved advert bits read 0
// (RL5) 100 full: RW, reset speed and duplex straps
// (RL6) 100 half: RW, reset speed strap
// (RL7) 10 full: RW, reset duplex strap
// (RL8) 10 half: RW, reset 1
// (RL9) Selector resets 00001; partner copy read-only
// (RL10) Partner ability read-only; bit14 word received
// (RL11) Partner fault and ability bits mirrored
// (RL12) Partner pause field decodes four ways
// (RL13) Parallel detect fault latches high; upper zero
// (RL14) Expansion reports partner next page able
// (RL15) Expansion local next page able reads 1
// (RL16) Page received latches high on page
// (RL17) Expansion reports partner auto-negotiation able
// (RL18) Next page, message, comply bits RW; 14 zero
// (RL19) Transmit toggle bit mirrors previous toggle
// (RL20) Eleven-bit message field RW, reset 001
// (RL21) Partner next page bits read-only, reset 0
// (RL22) Partner toggle bit reads inverse toggle
// (RL23) Latched flags clear on read unless active
// (RL24) Writes to read-only bits ignored
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module anpr_regs
	import anpr_pkg::*;
(
	// Clock and reset
	input  wire logic          CLK_SYS_I,
	input  wire logic          NRST_I,
	// Avalon-MM slave
	input  wire anpr_avs_req_t AVS_REQ_I,
	output logic [31:0]        AVS_READDATA_O,
	output logic               AVS_WAITREQUEST_O,
	// Straps, sampled during reset
	input  wire logic          SPEED_STRAP_PIN_I,
	input  wire logic          DUPLEX_STRAP_I,
	// From the negotiation engine
	input  wire logic [15:0]   LP_WORD_I,
	input  wire logic          LP_BASE_LD_I,
	input  wire logic          LP_NP_LD_I,
	input  wire logic          PD_FAULT_I,
	input  wire logic          LP_AN_ABLE_I,
	input  wire logic          TX_TOGGLE_I,
	// To the negotiation engine
	output logic [15:0]        ADV_WORD_O,
	output logic [15:0]        NP_TX_WORD_O
);

	anpr_state_t      st;
	anpr_state_t      nx;
	logic             req;
	logic             done;
	logic             rd_exp;
	logic             pg_evt;
	logic [IDX_W-1:0] idx;
	logic [15:0]      lane;
	logic [15:0]      rd_val;
	logic [15:0]      exp_val;

	assign idx = AVS_REQ_I.address[WRD_LSB +: IDX_W];
	assign req = AVS_REQ_I.read | AVS_REQ_I.write;
	// Transfer completes on the edge where waitrequest is seen low
	assign done = req & ~st.wreq;
	assign rd_exp = done & AVS_REQ_I.read & (idx == IDX_EXP);
	assign pg_evt = LP_BASE_LD_I | LP_NP_LD_I;
	assign lane = {{8{AVS_REQ_I.byteenable[1]}}, {8{AVS_REQ_I.byteenable[0]}}};

	// Live causes are folded in so an event caught mid-read is not lost
	always_comb begin
		exp_val = ZERO16;
		exp_val[B_PDF] = st.pdf | PD_FAULT_I; // RL13
		exp_val[B_LPNPA] = st.lpa[B_NP]; // RL14
		exp_val[B_NPA] = 1'b1; // RL15
		exp_val[B_PRX] = st.prx | pg_evt; // RL16
		exp_val[B_LPAN] = st.lpan; // RL17
	end

	// Unmapped words read as zero and still complete
	always_comb begin
		unique case (idx)
			IDX_ADV: begin
				rd_val = st.adv;
			end
			IDX_LPA: begin
				rd_val = st.lpa;
			end
			IDX_EXP: begin
				rd_val = exp_val;
			end
			IDX_NPTX: begin
				rd_val = st.np;
			end
			IDX_LPNP: begin
				rd_val = st.lpnp;
			end
			default: begin
				rd_val = ZERO16;
			end
		endcase
	end

	always_comb begin
		nx = st;
		nx.wreq = 1'b1;
		// One wait cycle, then the answer stands for one cycle
		if (req && st.wreq) begin
			nx.wreq = 1'b0;
			nx.rdata = {ZERO16, rd_val};
		end
		if (done && AVS_REQ_I.write) begin
			if (idx == IDX_ADV) begin
				nx.adv = (st.adv & ~(ADV_WMSK & lane))
					| (AVS_REQ_I.writedata[15:0] & ADV_WMSK & lane); // RL1 RL2 RL3 RL4 RL24
			end
			if (idx == IDX_NPTX) begin
				nx.np = (st.np & ~(NP_WMSK & lane))
					| (AVS_REQ_I.writedata[15:0] & NP_WMSK & lane); // RL18 RL20 RL24
			end
		end
		// Partner words keep their own pause pair; decode is software's
		if (LP_BASE_LD_I) begin
			nx.lpa = LP_WORD_I & LPA_MSK; // RL10 RL11 RL12
		end
		if (LP_NP_LD_I) begin
			nx.lpnp = (st.lpnp & ~LPNP_MSK) | (LP_WORD_I & LPNP_MSK); // RL21
		end
		nx.np[B_TOG] = TX_TOGGLE_I; // RL19
		nx.lpnp[B_TOG] = ~TX_TOGGLE_I; // RL22
		// Set wins over the clear by read
		nx.pdf = PD_FAULT_I | (st.pdf & ~rd_exp); // RL13 RL23
		nx.prx = pg_evt | (st.prx & ~rd_exp); // RL16 RL23
		nx.lpan = LP_AN_ABLE_I; // RL17
		if (!NRST_I) begin
			nx.wreq = 1'b1;
			nx.rdata = {ZERO16, ZERO16};
			nx.adv = ADV_RST; // RL8 RL9
			nx.adv[B_100FD] = SPEED_STRAP_PIN_I & DUPLEX_STRAP_I; // RL5
			nx.adv[B_100] = SPEED_STRAP_PIN_I; // RL6
			nx.adv[B_10FD] = DUPLEX_STRAP_I; // RL7
			nx.lpa = LPA_RST; // RL9 RL10
			nx.np = NP_RST; // RL18 RL20
			nx.lpnp = ZERO16; // RL21
			nx.pdf = 1'b0;
			nx.prx = 1'b0;
			nx.lpan = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		st <= nx;
	end

	assign AVS_READDATA_O = st.rdata;
	assign AVS_WAITREQUEST_O = st.wreq;
	assign ADV_WORD_O = st.adv;
	assign NP_TX_WORD_O = st.np;

	// Checks
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);

	sequence s_req_first;
		req && st.wreq;
	endsequence

	sequence s_ack;
		!st.wreq ##1 st.wreq;
	endsequence

	chk_bus_answer: assert property (s_req_first |=> s_ack) // RL24
		else $error("waitrequest did not pulse low once");

	chk_adv_ro_bits: assert property (st.adv[14] == 1'b0 && st.adv[12:11] == 2'b00 && st.adv[B_T4] == 1'b0) // RL4
		else $error("advert read-only bits not zero");

	chk_adv_reset: assert property (disable iff (1'b0)
		!NRST_I |=> st.adv[4:0] == 5'h01 && st.adv[5] && !st.adv[15] && !st.adv[13] && !st.adv[10]) // RL9
		else $error("advert reset value wrong");

	chk_strap_reset: assert property (disable iff (1'b0)
		!NRST_I |=> st.adv[B_100] == $past(SPEED_STRAP_PIN_I) && st.adv[B_10FD] == $past(DUPLEX_STRAP_I)) // RL6
		else $error("strap not taken at reset");

	chk_np_able: assert property (done && AVS_REQ_I.read && idx == IDX_EXP |-> st.rdata[B_NPA]) // RL15
		else $error("local next page able not one");

	chk_pdf_hold: assert property (st.pdf && !rd_exp |=> st.pdf) // RL23
		else $error("fault flag lost before read");

	chk_prx_clear: assert property (rd_exp && !pg_evt |=> !st.prx) // RL23
		else $error("page flag not cleared by read");

	// Reset loads both toggle bits as zero, so the first edge after release is skipped
	chk_toggle_pair: assert property (NRST_I |=> st.np[B_TOG] != st.lpnp[B_TOG]) // RL22
		else $error("toggle bits not inverse");

	chk_toggle_follow: assert property (NRST_I |=> st.np[B_TOG] == $past(TX_TOGGLE_I)) // RL19
		else $error("toggle not mirrored");

	chk_ro_write: assert property (done && AVS_REQ_I.write && idx == IDX_LPA && !LP_BASE_LD_I |=> $stable(st.lpa)) // RL24
		else $error("partner ability changed by write");

	chk_np_bit14: assert property (st.np[B_ACK] == 1'b0 && st.lpa[12] == 1'b0) // RL18
		else $error("reserved bit not zero");

	sequence s_adv_wr;
		done && AVS_REQ_I.write && idx == IDX_ADV && AVS_REQ_I.byteenable[1:0] == 2'b11;
	endsequence

	sequence s_np_wr;
		done && AVS_REQ_I.write && idx == IDX_NPTX && AVS_REQ_I.byteenable[1:0] == 2'b11;
	endsequence

	sequence s_exp_rd;
		rd_exp;
	endsequence

	sequence s_base_ld;
		LP_BASE_LD_I;
	endsequence

	property p_adv_np_wr;
		s_adv_wr |=> st.adv[B_NP] == $past(AVS_REQ_I.writedata[B_NP]);
	endproperty

	chk_adv_np_wr: assert property (p_adv_np_wr) // RL1
		else $error("next page advert not written");

	property p_adv_rf_wr;
		s_adv_wr |=> st.adv[B_RF] == $past(AVS_REQ_I.writedata[B_RF]);
	endproperty

	chk_adv_rf_wr: assert property (p_adv_rf_wr) // RL2
		else $error("remote fault advert not written");

	property p_adv_pause_wr;
		s_adv_wr |=> st.adv[10] == $past(AVS_REQ_I.writedata[10]);
	endproperty

	chk_adv_pause_wr: assert property (p_adv_pause_wr) // RL3
		else $error("pause advert not written");

	property p_adv_speed_wr;
		s_adv_wr |=> st.adv[B_100FD:B_10FD] == $past(AVS_REQ_I.writedata[B_100FD:B_10FD]);
	endproperty

	chk_adv_speed_wr: assert property (p_adv_speed_wr) // RL5 RL6 RL7
		else $error("speed advert bits not written");

	property p_adv_10_wr;
		s_adv_wr |=> st.adv[5] == $past(AVS_REQ_I.writedata[5]);
	endproperty

	chk_adv_10_wr: assert property (p_adv_10_wr) // RL8
		else $error("10 half advert not written");

	property p_adv_sel_wr;
		s_adv_wr |=> st.adv[4:0] == $past(AVS_REQ_I.writedata[4:0]);
	endproperty

	chk_adv_sel_wr: assert property (p_adv_sel_wr) // RL9
		else $error("selector not written");

	property p_lane_gate;
		done && AVS_REQ_I.write && idx == IDX_ADV && !AVS_REQ_I.byteenable[1] |=> st.adv[15:8] == $past(st.adv[15:8]);
	endproperty

	chk_lane_gate: assert property (p_lane_gate) // RL24
		else $error("disabled byte lane written");

	property p_lpa_load;
		s_base_ld |=> st.lpa == ($past(LP_WORD_I) & LPA_MSK);
	endproperty

	chk_lpa_load: assert property (p_lpa_load) // RL10 RL11
		else $error("partner ability not loaded");

	property p_lpa_pause;
		s_base_ld |=> st.lpa[11:10] == $past(LP_WORD_I[11:10]);
	endproperty

	chk_lpa_pause: assert property (p_lpa_pause) // RL12
		else $error("partner pause field not kept");

	property p_lpa_hold;
		!LP_BASE_LD_I |=> $stable(st.lpa);
	endproperty

	chk_lpa_hold: assert property (p_lpa_hold) // RL10
		else $error("partner ability changed without load");

	property p_exp_upper;
		s_exp_rd |-> st.rdata[15:5] == 11'h000;
	endproperty

	chk_exp_upper: assert property (p_exp_upper) // RL13
		else $error("expansion upper bits not zero");

	property p_pdf_set;
		PD_FAULT_I |=> st.pdf;
	endproperty

	chk_pdf_set: assert property (p_pdf_set) // RL13
		else $error("fault flag not set");

	property p_pdf_clear;
		rd_exp && !PD_FAULT_I |=> !st.pdf;
	endproperty

	chk_pdf_clear: assert property (p_pdf_clear) // RL23
		else $error("fault flag not cleared by read");

	property p_prx_set;
		pg_evt |=> st.prx;
	endproperty

	chk_prx_set: assert property (p_prx_set) // RL16
		else $error("page flag not set");

	property p_prx_hold;
		st.prx && !rd_exp |=> st.prx;
	endproperty

	chk_prx_hold: assert property (p_prx_hold) // RL23
		else $error("page flag lost before read");

	property p_lpnpa_rd;
		s_exp_rd |-> st.rdata[B_LPNPA] == $past(st.lpa[B_NP]);
	endproperty

	chk_lpnpa_rd: assert property (p_lpnpa_rd) // RL14
		else $error("partner next page able wrong");

	property p_lpan_rd;
		s_exp_rd |-> st.rdata[B_LPAN] == $past(st.lpan);
	endproperty

	chk_lpan_rd: assert property (p_lpan_rd) // RL17
		else $error("partner negotiation able wrong");

	property p_flag_rd;
		s_exp_rd |-> st.rdata[B_PDF] == $past(st.pdf | PD_FAULT_I) && st.rdata[B_PRX] == $past(st.prx | pg_evt);
	endproperty

	chk_flag_rd: assert property (p_flag_rd) // RL13 RL16
		else $error("latched flag read wrong");

	property p_np_wr;
		s_np_wr |=> st.np[15:12] == ($past(AVS_REQ_I.writedata[15:12]) & NP_WMSK[15:12])
			&& st.np[10:0] == $past(AVS_REQ_I.writedata[10:0]);
	endproperty

	chk_np_wr: assert property (p_np_wr) // RL18 RL20
		else $error("next page word not written");

	property p_np_other;
		done && AVS_REQ_I.write && idx != IDX_NPTX |=> st.np[15:12] == $past(st.np[15:12])
			&& st.np[10:0] == $past(st.np[10:0]);
	endproperty

	chk_np_other: assert property (p_np_other) // RL24
		else $error("next page word changed by other write");

	property p_rst_vals;
		disable iff (1'b0)
		!NRST_I |=> st.lpa == LPA_RST && st.np == NP_RST && st.lpnp == ZERO16 && !st.pdf && !st.prx;
	endproperty

	chk_rst_vals: assert property (p_rst_vals) // RL10 RL21
		else $error("register reset value wrong");

	property p_rd_upper;
		done && AVS_REQ_I.read |-> st.rdata[31:16] == ZERO16;
	endproperty

	chk_rd_upper: assert property (p_rd_upper) // RL24
		else $error("read data upper half not zero");

	property p_lpnp_load;
		LP_NP_LD_I |=> st.lpnp[15:12] == $past(LP_WORD_I[15:12]);
	endproperty

	chk_lpnp_load: assert property (p_lpnp_load) // RL21
		else $error("partner next page not loaded");

endmodule

// File: sim/anpr_lp_model.sv
// Link partner model that loads received pages into the bank
`timescale 1ns/1ps
module anpr_lp_model (
	// Clock
	input  wire logic   clk_i,
	// Page load towards the bank
	output logic [15:0] word_o,
	output logic        base_ld_o,
	output logic        np_ld_o
);
	initial begin
		word_o = 16'h0000;
		base_ld_o = 1'b0;
		np_ld_o = 1'b0;
	end
	// Word inverted after the strobe so stale data cannot pass
	task automatic send(input logic np, input logic [15:0] w);
		word_o <= w;
		base_ld_o <= !np;
		np_ld_o <= np;
		@(posedge clk_i);
		word_o <= ~w;
		base_ld_o <= 1'b0;
		np_ld_o <= 1'b0;
	endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the auto-negotiation page registers
`timescale 1ns/1ps
module tb_top;
	import anpr_pkg::*;
	logic          clk = 1'b0;
	logic          nrst = 1'b0;
	anpr_avs_req_t req = '0;
	logic [31:0]   rdata;
	logic          wait_r;
	logic          spd = 1'b1;
	logic          dup = 1'b1;
	logic          pdf = 1'b0;
	logic          an = 1'b0;
	logic          tog = 1'b0;
	logic [15:0]   lpw;
	logic [15:0]   adv;
	logic [15:0]   npw;
	logic [15:0]   q;
	logic          bld;
	logic          nld;
	logic [3:0]    be = 4'hF;
	int            failures = 0;
	int            tests_run = 0;
	// Address and expected read after writing all ones
	logic [21:0]   rows [6] = '{{6'h10, 16'hA5FF}, {6'h14, 16'h0001}, {6'h18, 16'h0004},
		{6'h1C, 16'hB7FF}, {6'h20, 16'h0800}, {6'h24, 16'h0000}};

	always #10 clk = ~clk;

	anpr_regs dut (.CLK_SYS_I(clk), .NRST_I(nrst), .AVS_REQ_I(req), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wait_r), .SPEED_STRAP_PIN_I(spd), .DUPLEX_STRAP_I(dup),
		.LP_WORD_I(lpw), .LP_BASE_LD_I(bld), .LP_NP_LD_I(nld), .PD_FAULT_I(pdf),
		.LP_AN_ABLE_I(an), .TX_TOGGLE_I(tog), .ADV_WORD_O(adv), .NP_TX_WORD_O(npw));

	anpr_lp_model lp (.clk_i(clk), .word_o(lpw), .base_ld_o(bld), .np_ld_o(nld));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a, output logic [15:0] r);
		int n;
		n = 0;
		req.read <= !wr;
		req.write <= wr;
		req.address <= a;
		req.byteenable <= be;
		req.writedata <= 32'h0000FFFF;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		if (wait_r !== 1'b0) begin
			failures++;
			finish_test();
		end
		r = rdata[15:0];
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rst(input logic s, input logic d);
		nrst <= 1'b0;
		spd <= s;
		dup <= d;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
	endtask

	initial begin
		rst(1'b1, 1'b1);
		foreach (rows[i]) begin
			bus(1'b1, rows[i][21:16], q);
			bus(1'b0, rows[i][21:16], q);
			chk(q, rows[i][15:0]);
			chk(rdata[31:16], ZERO16);
		end
		chk(adv, 16'hA5FF);
		for (int k = 0; k < 4; k++) begin
			rst(k[1], k[0]);
			chk(adv, {7'h00, k[1] & k[0], k[1], k[0], 6'h21});
			chk(npw, 16'h2001);
		end
		pdf <= 1'b1;
		@(posedge clk);
		pdf <= 1'b0;
		bus(1'b0, 6'h18, q);
		chk(q, 16'h0014);
		bus(1'b0, 6'h18, q);
		chk(q, 16'h0004);
		an <= 1'b1;
		tog <= 1'b1;
		lp.send(1'b0, 16'hFFFF);
		bus(1'b0, 6'h14, q);
		chk(q, 16'hEFFF);
		bus(1'b0, 6'h18, q);
		chk(q, 16'h000F);
		bus(1'b0, 6'h18, q);
		chk(q, 16'h000D);
		lp.send(1'b1, 16'hA7FF);
		bus(1'b0, 6'h20, q);
		chk(q, 16'hA000);
		bus(1'b0, 6'h1C, q);
		chk(q, 16'h2801);
		be = 4'h1;
		bus(1'b1, 6'h10, q);
		chk(adv, 16'h01FF);
		finish_test();
	end
endmodule
